// ---- design/crlpw_defs.svh ----
// Timing and field constants of the low-power arm and wake sequencer
`ifndef CRLPW_DEFS_SVH
`define CRLPW_DEFS_SVH
`define CRLPW_CLK_HZ 20000000
`define CRLPW_HOLD_LOW_MS 100
`define CRLPW_HOLD_LOW_CYC (`CRLPW_HOLD_LOW_MS * (`CRLPW_CLK_HZ / 1000))
`define CRLPW_ARM_WAIT_MS 300
`define CRLPW_ARM_WAIT_CYC (`CRLPW_ARM_WAIT_MS * (`CRLPW_CLK_HZ / 1000))
`define CRLPW_TRK_A 0
`define CRLPW_TRK_B 1
`define CRLPW_TRK_C 2
`endif

// ---- design/crlpw_pkg.sv ----
// Types of the low-power arm and wake sequencer
package crlpw_pkg;
	typedef enum logic [2:0] {
		CRLPW_OFF,
		CRLPW_ARMED,
		CRLPW_WAKE_HOLD,
		CRLPW_AWAKE,
		CRLPW_REGULAR
	} crlpw_state_t;
endpackage

// ---- design/crlpw_seq.sv ----
// Low-power arm and wake sequencer of the stripe reader head
`timescale 1ns/10ps
`default_nettype none
`include "crlpw_defs.svh"

module crlpw_seq #(
	parameter int HOLD_LOW_CYC = `CRLPW_HOLD_LOW_CYC,
	parameter int ARM_WAIT_CYC = `CRLPW_ARM_WAIT_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic strobe_in,
	input wire logic [2:0] head_act,
	input wire logic mount_reversed,
	output logic strobe_out,
	output logic strobe_oe,
	output logic decoder_on,
	output logic [2:0] mem_trk_en,
	output crlpw_pkg::crlpw_state_t state
);
	import crlpw_pkg::*;

	////////////////////////////////////////////////////////////////////////
	localparam int CW = 32;
	crlpw_state_t next_state;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic strobe_q;
	logic [2:0] trk_map;
	wire wake_trk2 = head_act[`CRLPW_TRK_B];
	wire strobe_rise = strobe_in & ~strobe_q;
	wire strobe_fall_host = ~strobe_in & strobe_q;
	wire hold_done = (cnt >= HOLD_LOW_CYC[CW-1:0] - 32'h1);
	wire arm_ok = (cnt >= ARM_WAIT_CYC[CW-1:0]);
	wire next_oe = (next_state == CRLPW_WAKE_HOLD);
	wire next_dec = (next_state == CRLPW_AWAKE) || (next_state == CRLPW_REGULAR);

	// Memory track A,B,C from head track 1,2,3 or reversed
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_map
			assign trk_map[g] = mount_reversed ? head_act[2-g] : head_act[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_cnt = cnt + 32'h1;
		case (state)
			CRLPW_OFF: begin
				// Host pulls strobe low after the wait: regular protocol
				if (!strobe_in && arm_ok) begin
					next_state = CRLPW_REGULAR;
				end else if (strobe_in && strobe_q && arm_ok) begin
					// A released line reads high through the pull-up, like a driven one
					next_state = CRLPW_ARMED;
				end
				if (strobe_rise) begin
					next_cnt = '0;
				end else if (arm_ok) begin
					next_cnt = cnt;
				end
			end
			CRLPW_ARMED: begin
				next_cnt = '0;
				if (wake_trk2) begin
					next_state = CRLPW_WAKE_HOLD;
				end else if (strobe_fall_host) begin
					// Host chose the regular protocol instead of waiting for a card
					next_state = CRLPW_REGULAR;
				end
			end
			CRLPW_WAKE_HOLD: begin
				if (hold_done) begin
					next_state = CRLPW_AWAKE;
					next_cnt = '0;
				end
			end
			CRLPW_AWAKE: begin
				next_cnt = cnt;
				if (strobe_rise) begin
					next_state = CRLPW_OFF;
					next_cnt = '0;
				end
			end
			CRLPW_REGULAR: begin
				next_cnt = cnt;
				if (strobe_rise) begin
					next_state = CRLPW_OFF;
					next_cnt = '0;
				end
			end
			default: begin
				next_state = CRLPW_OFF;
				next_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= CRLPW_OFF;
			cnt <= '0;
			strobe_q <= 1'b1;
			strobe_oe <= 1'b0;
			strobe_out <= 1'b0;
			decoder_on <= 1'b0;
			mem_trk_en <= 3'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			strobe_q <= strobe_in;
			strobe_oe <= next_oe;
			strobe_out <= 1'b0;
			decoder_on <= next_dec;
			mem_trk_en <= next_dec ? trk_map : 3'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Length of the current strobe pull-low, kept only for the checks below
	logic [CW-1:0] oe_run;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			oe_run <= '0;
		end else if (strobe_oe) begin
			oe_run <= oe_run + 32'h1;
		end else begin
			oe_run <= '0;
		end
	end

	sequence s_armed_wake;
		(state == CRLPW_ARMED) && wake_trk2;
	endsequence
	sequence s_armed_idle;
		(state == CRLPW_ARMED) && !wake_trk2;
	endsequence
	sequence s_hold_end;
		$fell(strobe_oe) ##0 !$past(sys_rst);
	endsequence
	sequence s_host_rise;
		((state == CRLPW_AWAKE) || (state == CRLPW_REGULAR)) && strobe_rise;
	endsequence
	sequence s_decode_step;
		decoder_on && $past(next_dec);
	endsequence

	// Wake from the armed state
	a_wake_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_armed_wake |=> strobe_oe)
		else $error("strobe not pulled low after wake");
	a_wake_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_armed_wake |=> (state == CRLPW_WAKE_HOLD))
		else $error("no hold state after wake");
	a_trk2_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_armed_idle |=> (state != CRLPW_WAKE_HOLD))
		else $error("woke without track 2");
	a_oe_wake_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(strobe_oe) |-> ($past(state) == CRLPW_ARMED) && $past(wake_trk2))
		else $error("strobe pulled low without a wake");

	// Strobe pull-low window
	a_hold_min: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_hold_end |-> (oe_run >= HOLD_LOW_CYC))
		else $error("strobe pull-low too short");
	a_pull_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
		strobe_oe |-> !strobe_out)
		else $error("strobe driven high");
	a_hold_state: assert property (@(posedge ref_clk) disable iff (sys_rst)
		strobe_oe |-> (state == CRLPW_WAKE_HOLD))
		else $error("strobe pulled low outside the hold");

	// Decoder power and track enables
	a_dec_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == CRLPW_ARMED) |-> !decoder_on)
		else $error("decoder on while armed");
	a_off_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == CRLPW_OFF) |-> !decoder_on && !strobe_oe)
		else $error("activity in the off state");
	a_trk_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!decoder_on |-> (mem_trk_en == 3'h0))
		else $error("track enabled with decoder off");
	a_dec_awake: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == CRLPW_AWAKE) |-> decoder_on)
		else $error("decoder off while awake");

	// Track mapping in both mounting orientations
	a_map_nominal: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_decode_step ##0 !$past(mount_reversed) |-> mem_trk_en == $past(head_act))
		else $error("track mapping wrong");
	a_map_reversed: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_decode_step ##0 $past(mount_reversed) |->
		mem_trk_en == {$past(head_act[0]), $past(head_act[1]), $past(head_act[2])})
		else $error("reversed track mapping wrong");

	// Regular protocol and return to off
	a_reg_no_pull: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == CRLPW_REGULAR) |-> !strobe_oe)
		else $error("strobe pulled low in regular protocol");
	a_regular_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_armed_idle ##0 strobe_fall_host |=> (state == CRLPW_REGULAR))
		else $error("host strobe fall did not select regular protocol");
	a_rise_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_host_rise |=> (state == CRLPW_OFF))
		else $error("strobe rise did not return to off");
endmodule // crlpw_seq
`default_nettype wire

// ---- tb/crlpw_host.sv ----
// Host model on the strobe line
`timescale 1ns/10ps
`default_nettype none
module crlpw_host (
	input wire logic ref_clk,
	input wire logic drv_en,
	input wire logic drv_lvl,
	input wire logic head_oe,
	input wire logic head_lvl,
	output logic line
);
	logic grab = 1'h0;
	always @(negedge ref_clk) begin
		if (head_oe && !head_lvl) grab <= 1'h1;
		else if (drv_en) grab <= 1'h0;
	end
	assign line = ((head_oe && !head_lvl) || grab || (drv_en && !drv_lvl)) ? 1'h0 : 1'h1;
endmodule // crlpw_host
`default_nettype wire

// ---- tb/test_card_reader_low_power_arm_wake.sv ----
// Testbench of the arm and wake sequencer
`timescale 1ns/10ps
`default_nettype none
module test_card_reader_low_power_arm_wake;
	import crlpw_pkg::*;
	logic ref_clk = 1'h0, sys_rst = 1'h1, de = 1'h1, dl = 1'h1, rev = 1'h0, sl, so, oe, dec;
	logic [2:0] act = 3'h0, trk;
	crlpw_state_t st;
	int mismatches = 0, n_compared = 0, n;
	always #25 ref_clk = ~ref_clk;
	crlpw_seq #(.HOLD_LOW_CYC(8), .ARM_WAIT_CYC(8)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.strobe_in(sl), .head_act(act), .mount_reversed(rev), .strobe_out(so), .strobe_oe(oe),
		.decoder_on(dec), .mem_trk_en(trk), .state(st));
	crlpw_host u_host (.ref_clk(ref_clk), .drv_en(de), .drv_lvl(dl), .head_oe(oe), .head_lvl(so), .line(sl));
	task chk(input logic [2:0] got, input logic [2:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task b(input logic got, input logic exp);
		chk({2'h0, got}, {2'h0, exp});
	endtask
	task tmo(input logic spent);
		b(spent, 1'h0);
		if (spent) final_report;
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask
	task off_wait;
		sys_rst = 1'h1;
		de = 1'h1;
		dl = 1'h1;
		act = 3'h0;
		cyc(4);
		sys_rst = 1'h0;
		cyc(10);
	endtask
	task scen_wake(input logic r, input logic [2:0] exp);
		rev = r;
		off_wait;
		de = 1'h0;
		cyc(2);
		chk(st, CRLPW_ARMED);
		b(dec, 1'h0);
		act = 3'h5;
		cyc(4);
		b(oe, 1'h0);
		act = 3'h3;
		n = 0;
		while (oe !== 1'h1 && n < 4) begin
			cyc(1);
			n++;
		end
		tmo(oe !== 1'h1);
		b(n < 4, 1'h1);
		b(so, 1'h0);
		n = 0;
		while (oe === 1'h1 && n < 20) begin
			cyc(1);
			n++;
		end
		tmo(oe === 1'h1);
		b(n >= 8, 1'h1);
		cyc(2);
		b(dec, 1'h1);
		chk(trk, exp);
	endtask
	task scen_reg;
		off_wait;
		dl = 1'h0;
		n = 0;
		while (st !== CRLPW_REGULAR && n < 4) begin
			cyc(1);
			n++;
		end
		tmo(st !== CRLPW_REGULAR);
		chk(st, CRLPW_REGULAR);
		dl = 1'h1;
		cyc(2);
		chk(st, CRLPW_OFF);
		b(dec, 1'h0);
	endtask
	initial begin
		scen_wake(1'h0, 3'h3);
		scen_wake(1'h1, 3'h6);
		scen_reg;
		final_report;
	end
endmodule // test_card_reader_low_power_arm_wake
`default_nettype wire
